// >>> pkg/aip_defs.svh
// constants for the alarm inhibit and input polarity block
`ifndef AIP_DEFS_SVH
`define AIP_DEFS_SVH

// ****************************************************************
// register word indices, compared against adr_i[5:2]
// ****************************************************************
`define AIP_OFS_SUP_AUX 4'h0
`define AIP_OFS_SUP_MISC 4'h1
`define AIP_OFS_POL 4'h2
`define AIP_OFS_VTYPE 4'h3
`define AIP_OFS_ROUTE_AUX 4'h4
`define AIP_OFS_ROUTE_MISC 4'h5
`define AIP_OFS_STAT 4'h6
`define AIP_OFS_MASK 4'h7
`define AIP_OFS_INPUTS 4'h8

// ****************************************************************
// field layout of the misc registers
// ****************************************************************
`define AIP_MISC_UC_BIT 0
`define AIP_MISC_TRIP_BIT 1
`define AIP_MISC_EQ_LSB 2
`define AIP_MISC_EQ_MSB 9

// ****************************************************************
// reset values
// ****************************************************************
`define AIP_RST_SUP_AUX 10'h000
`define AIP_RST_SUP_MISC 10'h002
`define AIP_RST_POL 6'h3f
`define AIP_RST_VTYPE 1'h0
`define AIP_RST_ROUTE 10'h000
`define AIP_RST_MASK 2'h0

// ****************************************************************
// ac detect: a level is kept this many cycles after the last high sample
// ****************************************************************
`define AIP_AC_HOLD_NS 10000000
`define AIP_CLK_NS 50
`define AIP_AC_HOLD_CYC (`AIP_AC_HOLD_NS / `AIP_CLK_NS)

`endif

// >>> pkg/aip_pkg.sv
// types for the alarm inhibit and input polarity block
package aip_pkg;

    typedef enum logic {
        AIP_VOLT_DC,
        AIP_VOLT_AC
    } aip_volt_t;

    typedef struct packed {
        logic [9:0] aux;
        logic under_current;
        logic control_trip;
        logic [7:0] equation;
    } aip_src_t;

    typedef enum logic [1:0] {
        AIP_BUS_IDLE,
        AIP_BUS_ACK
    } aip_bus_st_t;

endpackage

// >>> logic/aip_input_cond.sv
// one binary input: ac filtering and polarity
`timescale 1ns/1ps
`include "aip_defs.svh"

module aip_input_cond
    import aip_pkg::*;
#(
    parameter int HOLD_CYC = `AIP_AC_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic raw_i,
    input wire logic fitted_i,
    input wire logic polarity_i,
    input wire aip_volt_t vtype_i,
    output logic level_o,
    output logic active_o
);
    localparam int CW = $clog2(HOLD_CYC + 1);

    logic [CW-1:0] hold_q;
    logic level_q;

    // ****************************************************************
    // detection: ac retriggers on each high sample, so an ac input reads
    // high until it has been quiet for the hold time
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_q <= '0;
        end else if (raw_i) begin
            hold_q <= CW'(HOLD_CYC);
        end else if (hold_q != '0) begin
            hold_q <= hold_q - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_q <= 1'b0;
        end else if (vtype_i == AIP_VOLT_AC) begin
            level_q <= raw_i | (hold_q != '0);
        end else begin
            level_q <= raw_i;
        end
    end

    assign level_o = level_q;
    // polarity 1: active with voltage; 0: active without it
    assign active_o = fitted_i & (polarity_i ? level_q : ~level_q);
endmodule

// >>> logic/aip_top.sv
// alarm inhibit and input polarity configuration block
// ****************************************************************
// ****************************************************************
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "aip_defs.svh"

module aip_top
    import aip_pkg::*;
#(
    parameter int N_INPUTS = 6,
    parameter int HOLD_CYC = `AIP_AC_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // alarm sources, delayed and instantaneous
    input wire aip_src_t delayed_i,
    input wire logic [9:0] aux_inst_i,
    // binary inputs
    input wire logic [N_INPUTS-1:0] input_raw_i,
    input wire logic [N_INPUTS-1:0] input_fitted_i,
    output logic [N_INPUTS-1:0] input_active_o,
    // alarm outputs
    output logic alarm_led_o,
    output logic message_o,
    output aip_src_t message_src_o,
    output logic [9:0] aux_inst_msg_o,
    output logic irq_o
);

    // ****************************************************************
    // registers
    // ****************************************************************
    aip_src_t sup_q;
    aip_src_t route_q;
    logic [N_INPUTS-1:0] pol_q;
    aip_volt_t vtype_q;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [N_INPUTS-1:0] level_w;
    logic wr_w;
    logic rd_w;
    logic [3:0] idx_w;
    logic lo_ok;
    logic hi_ok;

    assign idx_w = adr_i[5:2];
    assign wr_w = cyc_i & stb_i & we_i & ~ack_q;
    assign rd_w = cyc_i & stb_i & ~we_i & ~ack_q;
    assign lo_ok = sel_i[0];
    assign hi_ok = sel_i[1];

    // ****************************************************************
    // bus answer: one registered ack per request, one wait state
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i & stb_i & ~ack_q;
        end
    end
    assign ack_o = ack_q;

    // ****************************************************************
    // suppress settings
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sup_q.aux <= `AIP_RST_SUP_AUX;
            // misc reset word uses the register layout, trip at bit 1
            {sup_q.equation, sup_q.control_trip, sup_q.under_current}
                <= `AIP_RST_SUP_MISC;
        end else if (wr_w && idx_w == `AIP_OFS_SUP_AUX) begin
            if (lo_ok) begin
                sup_q.aux[7:0] <= dat_i[7:0];
            end
            if (hi_ok) begin
                sup_q.aux[9:8] <= dat_i[9:8];
            end
        end else if (wr_w && idx_w == `AIP_OFS_SUP_MISC) begin
            if (lo_ok) begin
                sup_q.under_current <= dat_i[`AIP_MISC_UC_BIT];
                sup_q.control_trip <= dat_i[`AIP_MISC_TRIP_BIT];
                sup_q.equation[5:0] <= dat_i[7:`AIP_MISC_EQ_LSB];
            end
            if (hi_ok) begin
                sup_q.equation[7:6] <= dat_i[`AIP_MISC_EQ_MSB:8];
            end
        end
    end

    // ****************************************************************
    // routing to the first output relay, written over the bus
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_q.aux <= `AIP_RST_ROUTE;
            {route_q.equation, route_q.control_trip, route_q.under_current}
                <= `AIP_RST_ROUTE;
        end else if (wr_w && idx_w == `AIP_OFS_ROUTE_AUX) begin
            if (lo_ok) begin
                route_q.aux[7:0] <= dat_i[7:0];
            end
            if (hi_ok) begin
                route_q.aux[9:8] <= dat_i[9:8];
            end
        end else if (wr_w && idx_w == `AIP_OFS_ROUTE_MISC) begin
            if (lo_ok) begin
                route_q.under_current <= dat_i[`AIP_MISC_UC_BIT];
                route_q.control_trip <= dat_i[`AIP_MISC_TRIP_BIT];
                route_q.equation[5:0] <= dat_i[7:`AIP_MISC_EQ_LSB];
            end
            if (hi_ok) begin
                route_q.equation[7:6] <= dat_i[`AIP_MISC_EQ_MSB:8];
            end
        end
    end

    // ****************************************************************
    // input polarity and voltage type
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pol_q <= N_INPUTS'(`AIP_RST_POL);
        end else if (wr_w && lo_ok && idx_w == `AIP_OFS_POL) begin
            pol_q <= dat_i[N_INPUTS-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vtype_q <= aip_volt_t'(`AIP_RST_VTYPE);
        end else if (wr_w && lo_ok && idx_w == `AIP_OFS_VTYPE) begin
            vtype_q <= aip_volt_t'(dat_i[0]);
        end
    end

    // ****************************************************************
    // effective suppression and alarm drive
    // ****************************************************************
    aip_src_t eff_sup;
    aip_src_t raised;
    logic [9:0] inst_eff;
    logic [9:0] inst_raised;

    // routed sources keep their alarm whatever the setting
    assign eff_sup = sup_q & ~route_q;
    assign raised = delayed_i & ~eff_sup;
    // instantaneous aux twin follows the delayed setting
    assign inst_eff = eff_sup.aux;
    assign inst_raised = aux_inst_i & ~inst_eff;

    logic led_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_q <= 1'b0;
        end else begin
            led_q <= (|raised) | (|inst_raised);
        end
    end
    assign alarm_led_o = led_q;

    // message path: a registered snapshot of unsuppressed sources
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            message_src_o <= '0;
            aux_inst_msg_o <= '0;
        end else begin
            message_src_o <= raised;
            aux_inst_msg_o <= inst_raised;
        end
    end
    assign message_o = led_q;

    // ****************************************************************
    // interrupt: bit0 new alarm, bit1 input activity change
    // ****************************************************************
    logic [N_INPUTS-1:0] act_prev_q;
    logic alarm_rise;
    logic in_change;
    logic [1:0] clr_w;

    assign alarm_rise = ((|raised) | (|inst_raised)) & ~led_q;
    assign in_change = |(input_active_o ^ act_prev_q);
    assign clr_w = (wr_w && lo_ok && idx_w == `AIP_OFS_STAT) ?
        dat_i[1:0] : 2'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_prev_q <= '0;
        end else begin
            act_prev_q <= input_active_o;
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= 2'h0;
        end else begin
            stat_q <= (stat_q & ~clr_w) | {in_change, alarm_rise};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= `AIP_RST_MASK;
        end else if (wr_w && lo_ok && idx_w == `AIP_OFS_MASK) begin
            mask_q <= dat_i[1:0];
        end
    end
    assign irq_o = |(stat_q & mask_q);

    // ****************************************************************
    // binary inputs
    // ****************************************************************
    for (genvar g = 0; g < N_INPUTS; g++) begin : g_in
        aip_input_cond #(
            .HOLD_CYC(HOLD_CYC)
        ) u_cond (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .raw_i(input_raw_i[g]),
            .fitted_i(input_fitted_i[g]),
            .polarity_i(pol_q[g]),
            .vtype_i(vtype_q),
            .level_o(level_w[g]),
            .active_o(input_active_o[g])
        );
    end

    // ****************************************************************
    // read mux, unmapped reads return zero
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0;
        end else if (rd_w) begin
            unique case (idx_w)
                `AIP_OFS_SUP_AUX: rdat_q <= {22'h0, sup_q.aux};
                `AIP_OFS_SUP_MISC: rdat_q <= {22'h0, sup_q.equation,
                    sup_q.control_trip, sup_q.under_current};
                `AIP_OFS_POL: rdat_q <= 32'(pol_q & input_fitted_i);
                `AIP_OFS_VTYPE: rdat_q <= {31'h0, vtype_q};
                `AIP_OFS_ROUTE_AUX: rdat_q <= {22'h0, route_q.aux};
                `AIP_OFS_ROUTE_MISC: rdat_q <= {22'h0, route_q.equation,
                    route_q.control_trip, route_q.under_current};
                `AIP_OFS_STAT: rdat_q <= {30'h0, stat_q};
                `AIP_OFS_MASK: rdat_q <= {30'h0, mask_q};
                `AIP_OFS_INPUTS: rdat_q <= {16'h0, 2'h0,
                    6'(level_w), 2'h0, 6'(input_active_o)};
                default: rdat_q <= 32'h0;
            endcase
        end
    end
    assign dat_o = rdat_q;
endmodule

// >>> verif/aip_top_checker.sv
// assertion checker for the alarm inhibit and input polarity block
`timescale 1ns/1ps
`include "aip_defs.svh"

module aip_top_checker
    import aip_pkg::*;
#(
    parameter int N_INPUTS = 6,
    parameter int HOLD_CYC = `AIP_AC_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire aip_src_t delayed_i,
    input wire logic [9:0] aux_inst_i,
    input wire logic [N_INPUTS-1:0] input_raw_i,
    input wire logic [N_INPUTS-1:0] input_fitted_i,
    input wire logic [N_INPUTS-1:0] input_active_o,
    input wire logic alarm_led_o,
    input wire logic message_o,
    input wire aip_src_t message_src_o,
    input wire logic [9:0] aux_inst_msg_o
);
    // ****
    // shadow settings, rebuilt from bus writes
    // ****
    // limitation: byte enables are not followed, full writes assumed
    logic [9:0] sa_q, sm_q, ra_q, rm_q, eff_a, eff_m, src_m, msg_m;
    logic [N_INPUTS-1:0] pol_q;
    logic vt_q;
    assign eff_a = sa_q & ~ra_q;
    assign eff_m = sm_q & ~rm_q;
    assign src_m = {delayed_i.equation, delayed_i.control_trip,
        delayed_i.under_current};
    assign msg_m = {message_src_o.equation, message_src_o.control_trip,
        message_src_o.under_current};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sa_q <= `AIP_RST_SUP_AUX;
            sm_q <= `AIP_RST_SUP_MISC;
            ra_q <= `AIP_RST_ROUTE;
            rm_q <= `AIP_RST_ROUTE;
            pol_q <= N_INPUTS'(`AIP_RST_POL);
            vt_q <= `AIP_RST_VTYPE;
        end else if (cyc_i && stb_i && we_i && !ack_o) begin
            case (adr_i[5:2])
                `AIP_OFS_SUP_AUX: sa_q <= dat_i[9:0];
                `AIP_OFS_SUP_MISC: sm_q <= dat_i[9:0];
                `AIP_OFS_ROUTE_AUX: ra_q <= dat_i[9:0];
                `AIP_OFS_ROUTE_MISC: rm_q <= dat_i[9:0];
                `AIP_OFS_POL: pol_q <= dat_i[N_INPUTS-1:0];
                `AIP_OFS_VTYPE: vt_q <= dat_i[0];
                default: ;
            endcase
        end
    end

    // ****
    // properties
    // ****
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_MSG_AUX: assert property (!$past(rst_i) |->
        message_src_o.aux == ($past(delayed_i.aux) & ~$past(eff_a)))
        else $error("aux message wrong");
    AST_MSG_MISC: assert property (!$past(rst_i) |->
        msg_m == ($past(src_m) & ~$past(eff_m)))
        else $error("misc message wrong");
    AST_INST: assert property (!$past(rst_i) |->
        aux_inst_msg_o == ($past(aux_inst_i) & ~$past(eff_a)))
        else $error("instantaneous message wrong");
    AST_LED: assert property (
        alarm_led_o == (|message_src_o || |aux_inst_msg_o))
        else $error("led not or of messages");
    AST_MSG_LED: assert property (message_o == alarm_led_o)
        else $error("message flag differs from led");
    AST_ACK: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack not a one cycle answer");
    AST_POL: assert property (
        (!vt_q && $stable(input_raw_i) && $stable(input_fitted_i)
        && $stable(pol_q))[*3] |->
        input_active_o == (input_fitted_i & ~(input_raw_i ^ pol_q)))
        else $error("input status wrong");
    AST_AC: assert property (
        (vt_q && pol_q[0] && input_fitted_i[0] && input_raw_i[0])[*2]
        ##1 (vt_q && !input_raw_i[0]) |=> input_active_o[0])
        else $error("ac input dropped early");
endmodule

bind aip_top aip_top_checker #(.N_INPUTS(N_INPUTS), .HOLD_CYC(HOLD_CYC))
    u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o),
    .delayed_i(delayed_i), .aux_inst_i(aux_inst_i),
    .input_raw_i(input_raw_i), .input_fitted_i(input_fitted_i),
    .input_active_o(input_active_o), .alarm_led_o(alarm_led_o),
    .message_o(message_o), .message_src_o(message_src_o),
    .aux_inst_msg_o(aux_inst_msg_o));

// >>> verif/aip_input_model.sv
// binary input field model: control voltage per input, dc or ac
`timescale 1ns/1ps

module aip_input_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [5:0] volt_i,
    input wire logic ac_i,
    output logic [5:0] raw_o
);
    // ****
    // ac supply sits at zero for two cycles out of every four
    // ****
    // a plain level detector would see an ac input drop out
    logic [1:0] ph_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_q <= 2'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
        end
    end
    assign raw_o = ac_i ? (volt_i & {6{ph_q[1]}}) : volt_i;
endmodule

// >>> verif/tb.sv
// self-checking bench for the alarm inhibit and input polarity block
`timescale 1ns/1ps
`include "aip_defs.svh"

module tb;
    import aip_pkg::*;
    localparam int HOLD = 4;
    logic clk_i, rst_i, cyc, stb, we, ack, led, msg, irq, ac, hold;
    logic [5:0] adr, volt, fit, raw, act;
    logic [31:0] dat, rdat, dout, e;
    logic [9:0] inst, imsg;
    aip_src_t src, msrc;
    int err_total, tests_run;

    aip_input_model u_field (.clk_i(clk_i), .rst_i(rst_i), .volt_i(volt),
        .ac_i(ac), .raw_o(raw));
    aip_top #(.N_INPUTS(6), .HOLD_CYC(HOLD)) dut (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hf), .dat_i(dat), .dat_o(dout), .ack_o(ack),
        .delayed_i(src), .aux_inst_i(inst), .input_raw_i(raw),
        .input_fitted_i(fit), .input_active_o(act), .alarm_led_o(led),
        .message_o(msg), .message_src_o(msrc), .aux_inst_msg_o(imsg),
        .irq_o(irq));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ****
    // tasks
    // ****
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            err_total++;
            $display("unexpected at %0t ns: got %h, want %h", $time, g, x);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic bus(input logic w, input logic [3:0] i,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'h0};
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            err_total++;
            finish_test();
        end else begin
            rdat = dout;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask

    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        bus(1'b1, i, d);
    endtask

    task automatic rd(input logic [3:0] i, input logic [31:0] x);
        bus(1'b0, i, 32'h0);
        chk(rdat, x);
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        err_total = 0;
        tests_run = 0;
        {cyc, stb, we, ac} = 4'h0;
        adr = 6'h00;
        dat = 32'h0;
        src = '0;
        inst = 10'h000;
        volt = 6'h00;
        fit = 6'h3f;
        rst_i = 1'b1;
        tick(8);
        rst_i <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            e = (k == 1) ? `AIP_RST_SUP_MISC : (k == 2) ? `AIP_RST_POL : 0;
            rd(4'(k), e);
        end
        src <= aip_src_t'(20'h00100);
        tick(3);
        chk(led, 32'h0);
        src <= aip_src_t'(20'h00400);
        tick(3);
        chk({led, msg}, 32'h3);
        rd(4'h6, 32'h1);
        chk(irq, 32'h0);
        wr(4'h7, 32'h1);
        tick(2);
        chk(irq, 32'h1);
        wr(4'h6, 32'h1);
        tick(2);
        chk(irq, 32'h0);
        src <= '0;
        // config 0 suppressed, 1 suppressed but routed, 2 not suppressed
        for (int c = 0; c < 3; c++) begin
            wr(4'h0, c == 2 ? 32'h0 : 32'h3ff);
            wr(4'h1, c == 2 ? 32'h0 : 32'h3ff);
            wr(4'h4, c == 1 ? 32'h3ff : 32'h0);
            wr(4'h5, c == 1 ? 32'h3ff : 32'h0);
            for (int i = 0; i < 20; i++) begin
                src <= aip_src_t'(20'h1 << i);
                tick(3);
                chk({led, msg}, c == 0 ? 32'h0 : 32'h3);
                chk(msrc, c == 0 ? 32'h0 : 32'h1 << i);
            end
            src <= '0;
        end
        wr(4'h0, 32'h001);
        inst <= 10'h3ff;
        tick(3);
        chk(imsg, 32'h3fe);
        inst <= 10'h000;
        volt <= 6'h05;
        tick(4);
        chk(act, 32'h05);
        rd(4'h6, 32'h3);
        wr(4'h2, 32'h0);
        tick(4);
        chk(act, 32'h3a);
        fit <= 6'h0f;
        tick(3);
        chk(act, 32'h0a);
        rd(4'h8, 32'h050a);
        fit <= 6'h3f;
        wr(4'h2, 32'h3f);
        wr(4'h3, 32'h1);
        rd(4'h3, 32'h1);
        volt <= 6'h01;
        ac <= 1'b1;
        tick(6);
        hold = 1'b1;
        for (int k = 0; k < 12; k++) begin
            tick(1);
            hold = hold & act[0];
        end
        chk(hold, 32'h1);
        wr(4'h3, 32'h0);
        tick(4);
        for (int k = 0; k < 8; k++) begin
            tick(1);
            hold = hold & act[0];
        end
        chk(hold, 32'h0);
        ac <= 1'b0;
        wr(4'h3, 32'h1);
        tick(6);
        volt <= 6'h00;
        tick(2);
        chk(act, 32'h01);
        tick(HOLD + 4);
        chk(act, 32'h00);
        finish_test();
    end
endmodule
